// [hw/serial_pkt_pkg.sv]
// Constants, register map and types of the serial packetizer
package serial_pkt_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int BPS_MIN = 110;
  localparam int BPS_MAX = 230_400;
  localparam int BPS_RST = 115_200;
  localparam logic [17:0] DIV_MAX = 18'(CLK_HZ / BPS_MIN);
  localparam logic [17:0] DIV_MIN = 18'(CLK_HZ / BPS_MAX);
  localparam logic [17:0] DIV_RST = 18'(CLK_HZ / BPS_RST);
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_DELIM = 8'h08;
  localparam logic [7:0] A_FLUSH = 8'h0c;
  localparam logic [7:0] A_INACT = 8'h10;
  localparam logic [7:0] A_NIDLE = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // Control fields
  localparam int C_DBITS = 0;
  localparam int C_STOP = 2;
  localparam int C_PAR = 4;
  localparam int C_FLOW = 7;
  localparam int C_FIFO = 9;
  localparam logic [9:0] CTRL_RST = 10'h283;
  // Delimiter fields
  localparam int D_VAL1 = 0;
  localparam int D_VAL2 = 8;
  localparam int D_EN1 = 16;
  localparam int D_EN2 = 17;
  // Status fields and network idle limits
  localparam int S_ERR = 13;
  localparam logic [6:0] NIDLE_RST = 7'h07;
  localparam logic [6:0] NIDLE_MAX = 7'h63;
  // Timing
  localparam int MS_UNIT_MS = 1;
  localparam int MS_CYC = CLK_HZ / 1000 * MS_UNIT_MS;
  localparam logic [15:0] MIN_MS = 16'hea60;
  // Sizes and in-band flow characters
  localparam int FIFO_DEPTH_DOC = 16;
  localparam int BUF_BYTES_DOC = 1024;
  localparam int FIFO_HEADROOM = 4;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  typedef enum logic [2:0] {
    PAR_NONE = 3'h0, PAR_EVEN = 3'h1, PAR_ODD = 3'h2,
    PAR_SPACE = 3'h3, PAR_MARK = 3'h4
  } parity_t;
  typedef enum logic [1:0] {
    FLOW_NONE = 2'h0, FLOW_RTS = 2'h1, FLOW_DTR = 2'h2, FLOW_XON = 2'h3
  } flow_t;
endpackage

// [hw/serial_rx_packetizer.sv]
// Serial port framer, FIFOs, packing buffer and connection timers
// Functional notes
// - Bit rate 110 bit/s to 230.4 kbit/s, 115.2 kbit/s after reset.
// - 5 to 8 data bits, 1/1.5/2 stop; 5 bits forces 1.5 stop.
// - Parity none, even, odd, space or mark; none after reset.
// - Flow control none, RTS/CTS, DTR/DSR or Xon/Xoff; RTS/CTS default.
// - 16-byte transmit and receive FIFOs, enabled by default, can be off.
// - Two flush bytes received in turn flush the buffer as one packet.
// - With second flush byte off, first flush byte alone flushes.
// - A full 1 KB buffer is packed and sent regardless of delimiters.
// - Packing buffer holds 1 KB of serial data.
// - Idle flush timeout 0 to 65535 ms, 0 disables, default 0.
// - Without delimiter, send only on full buffer or idle timeout.
// - Serial inactivity timer 0 to 65535 ms asks to close connection.
// - Network idle timer 0 to 99 minutes, default 7, asks to close.
// - After an inactivity close the device listens again.
// - Network data goes to the serial transmitter in FIFO order.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Write and read sides
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic rd_in,
  input wire logic [$clog2(DEPTH):0] limit_in,
  output logic [7:0] rdata_out,
  output logic [$clog2(DEPTH):0] count_out,
  output logic full_out,
  output logic empty_out
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  wire push = wr_in & ~full_out;
  wire pop = rd_in & ~empty_out;
  assign full_out = count_out >= limit_in;
  assign empty_out = count_out == '0;
  assign rdata_out = mem[rp];
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wp] <= wdata_in;
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp <= '0;
      rp <= '0;
      count_out <= '0;
    end else begin
      wp <= wp + AW'(push);
      rp <= rp + AW'(pop);
      count_out <= count_out + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

module serial_rx_packetizer import serial_pkt_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DOC,
  parameter int BUF_BYTES = BUF_BYTES_DOC,
  parameter int MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Serial pins
  input wire logic rxd_in,
  input wire logic cts_in,
  input wire logic dsr_in,
  output logic txd_out,
  output logic rts_out,
  output logic dtr_out,
  // Network to serial stream
  input wire logic [7:0] net_data_in,
  input wire logic net_valid_in,
  output logic net_ready_out,
  // Packets to network
  output logic [7:0] pkt_data_out,
  output logic pkt_valid_out,
  output logic pkt_last_out,
  output logic [$clog2(BUF_BYTES):0] pkt_len_out,
  input wire logic pkt_ready_in,
  // Connection state
  input wire logic net_activity_in,
  input wire logic net_connect_in,
  output logic close_req_out,
  output logic listening_out
);
  localparam int FW = $clog2(FIFO_DEPTH) + 1;
  localparam int BW = $clog2(BUF_BYTES) + 1;
  generate
    if (FIFO_DEPTH < 2 * FIFO_HEADROOM || (1 << (FW - 1)) != FIFO_DEPTH ||
        (1 << (BW - 1)) != BUF_BYTES || MS_CYCLES < 2) begin : g_bad
      $error("serial_rx_packetizer: unsupported parameter values");
    end
  endgenerate
  typedef enum logic [1:0] {PK_FILL = 2'b01, PK_SEND = 2'b10} pack_t;

  // Pin synchronisers {dsr, cts, rxd}
  logic [2:0] pin_m;
  logic [2:0] pin_s;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_m <= 3'h1;
      pin_s <= 3'h1;
    end else begin
      pin_m <= {dsr_in, cts_in, rxd_in};
      pin_s <= pin_m;
    end
  end
  wire rxd_s = pin_s[0];

  // Configuration
  logic [9:0] ctrl;
  logic [17:0] div;
  logic [17:0] delim;
  logic [15:0] flush_ms;
  logic [15:0] inact_ms;
  logic [6:0] nidle;
  logic [2:0] err;
  wire [1:0] dbits = ctrl[C_DBITS +: 2];
  wire [3:0] nbits = 4'(5 + dbits);
  wire [2:0] par_mode = ctrl[C_PAR +: 3];
  wire par_on = par_mode != PAR_NONE;
  wire [1:0] flow = ctrl[C_FLOW +: 2];
  wire [FW-1:0] limit = ctrl[C_FIFO] ? FW'(FIFO_DEPTH) : FW'(1);
  wire [2:0] stop_halves = (dbits == 2'h0) ? 3'h3 :
    3'(2 + ctrl[C_STOP +: 2]);
  wire [7:0] dmask = 8'hff >> (4'h8 - nbits);
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [2:0] m);
    case (m)
      PAR_EVEN: par_bit = ^d;
      PAR_ODD: par_bit = ~^d;
      PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // APB decode; access phase is two cycles, pready from a flop
  wire apb_acc = psel_in & penable_in;
  wire apb_wr = apb_acc & pready_out & pwrite_in;
  wire hit = paddr_in inside {A_CTRL, A_BAUD, A_DELIM, A_FLUSH, A_INACT,
                              A_NIDLE, A_STAT};
  wire wr_ok = apb_wr & hit;
  wire [17:0] wdiv = pwdata_in[17:0] < DIV_MIN ? DIV_MIN :
    pwdata_in[17:0] > DIV_MAX ? DIV_MAX : pwdata_in[17:0];
  wire [6:0] wnidle = pwdata_in[6:0] > NIDLE_MAX ? NIDLE_MAX :
    pwdata_in[6:0];

  // Status sources
  logic [BW-1:0] pcount;
  pack_t pk_state;
  wire [FW-1:0] rxf_cnt;
  wire [FW-1:0] txf_cnt;
  wire [31:0] status = {6'h0, 5'(txf_cnt), 5'(rxf_cnt), err,
    pk_state == PK_SEND, ~listening_out, 11'(pcount)};
  wire [31:0] rd_mux =
    paddr_in == A_CTRL ? {22'h0, ctrl} :
    paddr_in == A_BAUD ? {14'h0, div} :
    paddr_in == A_DELIM ? {14'h0, delim} :
    paddr_in == A_FLUSH ? {16'h0, flush_ms} :
    paddr_in == A_INACT ? {16'h0, inact_ms} :
    paddr_in == A_NIDLE ? {25'h0, nidle} :
    paddr_in == A_STAT ? status : 32'h0;
  logic [2:0] err_set;
  wire [2:0] err_clr = (wr_ok && paddr_in == A_STAT) ?
    pwdata_in[S_ERR +: 3] : 3'h0;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
      ctrl <= CTRL_RST;
      div <= DIV_RST;
      delim <= 18'h0;
      flush_ms <= 16'h0;
      inact_ms <= 16'h0;
      nidle <= NIDLE_RST;
      err <= 3'h0;
    end else begin
      pready_out <= apb_acc & ~pready_out;
      pslverr_out <= apb_acc & ~pready_out & ~hit;
      prdata_out <= (apb_acc & ~pwrite_in & ~pready_out) ? rd_mux : 32'h0;
      // Set wins over a same-cycle clear
      err <= (err & ~err_clr) | err_set;
      if (wr_ok) begin
        case (paddr_in)
          A_CTRL: ctrl <= pwdata_in[9:0];
          A_BAUD: div <= wdiv;
          A_DELIM: delim <= pwdata_in[17:0];
          A_FLUSH: flush_ms <= pwdata_in[15:0];
          A_INACT: inact_ms <= pwdata_in[15:0];
          A_NIDLE: nidle <= wnidle;
          default: ;
        endcase
      end
    end
  end

  // Receiver: samples mid-bit, checks the first stop bit only
  logic rx_busy;
  logic rx_done;
  logic [3:0] rx_idx;
  logic [17:0] rx_tmr;
  logic [11:0] rx_bits;
  wire [3:0] rx_last = 4'(nbits + 4'h1 + 4'(par_on));
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_idx <= 4'h0;
      rx_tmr <= 18'h0;
      rx_bits <= 12'h0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rxd_s) begin
          rx_busy <= 1'b1;
          rx_idx <= 4'h0;
          rx_tmr <= div >> 1;
        end
      end else if (rx_tmr != 18'h0) begin
        rx_tmr <= rx_tmr - 18'h1;
      end else begin
        rx_bits[rx_idx] <= rxd_s;
        rx_tmr <= div - 18'h1;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0 && rxd_s) begin
          rx_busy <= 1'b0;
        end else if (rx_idx == rx_last) begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
        end
      end
    end
  end
  wire [7:0] rx_byte = rx_bits[8:1] & dmask;
  wire par_err = par_on && rx_bits[nbits + 4'h1] != par_bit(rx_byte, par_mode);
  wire frm_err = ~rx_bits[rx_last];
  wire is_ctl = flow == FLOW_XON &&
    (rx_byte == XON_CHAR || rx_byte == XOFF_CHAR);
  wire rx_store = rx_done & ~par_err & ~frm_err & ~is_ctl;

  // FIFOs
  wire rxf_full;
  wire rxf_empty;
  wire [7:0] rxf_data;
  wire rxf_pop;
  wire txf_full;
  wire txf_empty;
  wire [7:0] txf_data;
  wire txf_pop;
  wire net_wr = net_valid_in & net_ready_out;
  assign err_set = {rx_store & rxf_full, rx_done & frm_err,
    rx_done & par_err};
  byte_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .wr_in(rx_store), .wdata_in(rx_byte), .rd_in(rxf_pop),
    .limit_in(limit), .rdata_out(rxf_data), .count_out(rxf_cnt),
    .full_out(rxf_full), .empty_out(rxf_empty));
  byte_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .wr_in(net_wr), .wdata_in(net_data_in), .rd_in(txf_pop),
    .limit_in(limit), .rdata_out(txf_data), .count_out(txf_cnt),
    .full_out(txf_full), .empty_out(txf_empty));
  wire [FW:0] txf_next = (FW+1)'(txf_cnt) + (FW+1)'(net_wr) -
    (FW+1)'(txf_pop);

  // Flow control; receive side throttles 4 bytes before the FIFO fills, or at its one byte with the FIFO off
  wire rx_stop = rxf_cnt >= (ctrl[C_FIFO] ?
    FW'(FIFO_DEPTH - FIFO_HEADROOM) : FW'(1));
  logic xoff_rcvd;
  logic stop_sent;
  wire ctl_pend = flow == FLOW_XON && rx_stop != stop_sent;
  wire tx_allow = flow == FLOW_RTS ? pin_s[1] :
    flow == FLOW_DTR ? pin_s[2] : flow == FLOW_XON ? ~xoff_rcvd : 1'b1;

  // Transmitter, timed in half bits for the 1.5 stop case
  logic tx_busy;
  logic [4:0] tx_half;
  logic [17:0] tx_tmr;
  logic [11:0] tx_frame;
  logic [4:0] tx_end;
  wire tx_load = ~tx_busy & (ctl_pend | (~txf_empty & tx_allow));
  assign txf_pop = tx_load & ~ctl_pend;
  wire [7:0] tx_sel = ctl_pend ? (rx_stop ? XOFF_CHAR : XON_CHAR) :
    txf_data & dmask;
  wire [11:0] tx_build = {3'h0, tx_sel, 1'b0} |
    (12'(par_bit(tx_sel, par_mode) & par_on) << (nbits + 4'h1)) |
    (12'hfff << (nbits + 4'h1 + 4'(par_on)));
  wire [17:0] half_div = div >> 1;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_busy <= 1'b0;
      tx_half <= 5'h0;
      tx_tmr <= 18'h0;
      tx_frame <= 12'hfff;
      tx_end <= 5'h0;
      txd_out <= 1'b1;
      stop_sent <= 1'b0;
      xoff_rcvd <= 1'b0;
      rts_out <= 1'b0;
      dtr_out <= 1'b0;
      net_ready_out <= 1'b0;
    end else begin
      txd_out <= tx_busy ? tx_frame[tx_half[4:1]] : 1'b1;
      rts_out <= ~(flow == FLOW_RTS && rx_stop);
      dtr_out <= ~(flow == FLOW_DTR && rx_stop);
      net_ready_out <= txf_next < (FW+1)'(limit);
      if (flow != FLOW_XON) begin
        xoff_rcvd <= 1'b0;
        stop_sent <= 1'b0;
      end else if (rx_done && !frm_err && is_ctl) begin
        xoff_rcvd <= rx_byte == XOFF_CHAR;
      end
      if (tx_load) begin
        tx_busy <= 1'b1;
        tx_half <= 5'h0;
        tx_tmr <= half_div - 18'h1;
        tx_frame <= tx_build;
        tx_end <= 5'({nbits + 4'h1 + 4'(par_on), 1'b0}) + 5'(stop_halves);
        if (ctl_pend) begin
          stop_sent <= rx_stop;
        end
      end else if (tx_busy) begin
        if (tx_tmr != 18'h0) begin
          tx_tmr <= tx_tmr - 18'h1;
        end else begin
          tx_tmr <= half_div - 18'h1;
          tx_half <= tx_half + 5'h1;
          if (tx_half + 5'h1 == tx_end) begin
            tx_busy <= 1'b0;
          end
        end
      end
    end
  end

  // Timers
  logic [23:0] ms_pre;
  logic ms_tick;
  logic [15:0] fl_cnt;
  logic [15:0] in_cnt;
  logic [15:0] min_pre;
  logic [6:0] nmin;
  logic flush_done;
  wire ser_evt = rx_done | tx_load;
  wire net_evt = net_activity_in | net_wr | (pkt_valid_out & pkt_ready_in);
  wire close_evt = ~listening_out &
    ((inact_ms != 16'h0 && in_cnt >= inact_ms) ||
     (nidle != 7'h0 && nmin >= nidle));
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ms_pre <= 24'h0;
      ms_tick <= 1'b0;
      fl_cnt <= 16'h0;
      in_cnt <= 16'h0;
      min_pre <= 16'h0;
      nmin <= 7'h0;
      close_req_out <= 1'b0;
      listening_out <= 1'b1;
    end else begin
      ms_tick <= ms_pre == 24'(MS_CYCLES - 1);
      ms_pre <= ms_pre == 24'(MS_CYCLES - 1) ? 24'h0 : ms_pre + 24'h1;
      if (ser_evt || flush_done) begin
        fl_cnt <= 16'h0;
      end else if (ms_tick && fl_cnt != 16'hffff) begin
        fl_cnt <= fl_cnt + 16'h1;
      end
      if (ser_evt || listening_out) begin
        in_cnt <= 16'h0;
      end else if (ms_tick && in_cnt != 16'hffff) begin
        in_cnt <= in_cnt + 16'h1;
      end
      if (net_evt || listening_out) begin
        min_pre <= 16'h0;
        nmin <= 7'h0;
      end else if (ms_tick) begin
        min_pre <= min_pre == MIN_MS - 16'h1 ? 16'h0 : min_pre + 16'h1;
        if (min_pre == MIN_MS - 16'h1 && nmin != 7'h7f) begin
          nmin <= nmin + 7'h1;
        end
      end
      close_req_out <= close_evt;
      listening_out <= close_evt | (listening_out & ~net_connect_in);
    end
  end

  // Packing buffer
  logic [7:0] pbuf [BUF_BYTES];
  logic [BW-1:0] rd_idx;
  logic d1_seen;
  wire pk_pop = pk_state == PK_FILL && !rxf_empty &&
    pcount < BW'(BUF_BYTES);
  assign rxf_pop = pk_pop;
  wire m1 = delim[D_EN1] && rxf_data == delim[D_VAL1 +: 8];
  wire m2 = delim[D_EN2] && d1_seen && rxf_data == delim[D_VAL2 +: 8];
  wire delim_hit = delim[D_EN1] && (delim[D_EN2] ? m2 : m1);
  wire full_hit = pcount == BW'(BUF_BYTES - 1);
  wire idle_hit = flush_ms != 16'h0 && fl_cnt == flush_ms &&
    pcount != '0;
  wire go_send = pk_pop ? (delim_hit | full_hit) : idle_hit;
  wire [BW-1:0] next_count = pcount + BW'(pk_pop);
  wire pk_adv = ~pkt_valid_out | pkt_ready_in;
  always_ff @(posedge clk_sys_in) begin
    if (pk_pop) begin
      pbuf[pcount[BW-2:0]] <= rxf_data;
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pk_state <= PK_FILL;
      pcount <= '0;
      rd_idx <= '0;
      d1_seen <= 1'b0;
      flush_done <= 1'b0;
      pkt_data_out <= 8'h0;
      pkt_valid_out <= 1'b0;
      pkt_last_out <= 1'b0;
      pkt_len_out <= '0;
    end else begin
      flush_done <= 1'b0;
      case (pk_state)
        PK_FILL: begin
          pcount <= next_count;
          if (pk_pop) begin
            d1_seen <= m1;
          end
          if (go_send) begin
            pk_state <= PK_SEND;
            pkt_len_out <= next_count;
            rd_idx <= '0;
          end
        end
        PK_SEND: begin
          if (pk_adv) begin
            if (rd_idx != pcount) begin
              pkt_data_out <= pbuf[rd_idx[BW-2:0]];
              pkt_valid_out <= 1'b1;
              pkt_last_out <= rd_idx == pcount - BW'(1);
              rd_idx <= rd_idx + BW'(1);
            end else begin
              pkt_valid_out <= 1'b0;
              pkt_last_out <= 1'b0;
              pk_state <= PK_FILL;
              pcount <= '0;
              d1_seen <= 1'b0;
              flush_done <= 1'b1;
            end
          end
        end
        default: pk_state <= PK_FILL;
      endcase
    end
  end
endmodule // serial_rx_packetizer

// [dv/serial_rx_packetizer_props.sv]
// Checker on the packet, serial and connection ports of the packetizer
`timescale 1ns/10ps
module serial_rx_packetizer_props #(
  parameter int BUF_BYTES = 1024
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Watched ports
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic txd_out,
  input wire logic [7:0] pkt_data_out,
  input wire logic pkt_valid_out,
  input wire logic pkt_last_out,
  input wire logic [$clog2(BUF_BYTES):0] pkt_len_out,
  input wire logic pkt_ready_in,
  input wire logic net_connect_in,
  input wire logic close_req_out,
  input wire logic listening_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  property p_pkt_hold;
    pkt_valid_out && !pkt_ready_in |=> pkt_valid_out &&
      $stable(pkt_data_out) && $stable(pkt_last_out);
  endproperty
  a_pkt_hold: assert property (p_pkt_hold)
    else $error("packet byte changed while stalled");
  property p_len_stable;
    pkt_valid_out && !(pkt_ready_in && pkt_last_out) |=>
      $stable(pkt_len_out);
  endproperty
  a_len_stable: assert property (p_len_stable)
    else $error("packet length moved inside a packet");
  property p_last_end;
    pkt_valid_out && pkt_ready_in && pkt_last_out |=> !pkt_valid_out;
  endproperty
  a_last_end: assert property (p_last_end)
    else $error("packet stream ran past last byte");
  property p_len_max;
    pkt_valid_out |-> pkt_len_out != 0 && pkt_len_out <= BUF_BYTES;
  endproperty
  a_len_max: assert property (p_len_max)
    else $error("packet length outside buffer size");
  property p_close_pulse;
    close_req_out |=> !close_req_out;
  endproperty
  a_close_pulse: assert property (p_close_pulse)
    else $error("close request longer than one cycle");
  property p_close_listen;
    close_req_out |-> ##[0:1] listening_out;
  endproperty
  a_close_listen: assert property (p_close_listen)
    else $error("no listening after close");
  property p_connect;
    net_connect_in && !close_req_out |=> !listening_out;
  endproperty
  a_connect: assert property (p_connect)
    else $error("still listening after connect");
  // Any low level on the line lasts at least nine clock cycles
  property p_min_bit;
    $fell(txd_out) |=> !txd_out [*8];
  endproperty
  a_min_bit: assert property (p_min_bit)
    else $error("serial bit shorter than fastest rate");
  c_pkt_end: cover property (pkt_valid_out && pkt_ready_in && pkt_last_out);
  c_close: cover property (close_req_out);
  c_slverr: cover property (pready_out && pslverr_out);
endmodule // serial_rx_packetizer_props

bind serial_rx_packetizer serial_rx_packetizer_props #(
  .BUF_BYTES(BUF_BYTES)
) i_serial_rx_packetizer_props (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .txd_out(txd_out),
  .pkt_data_out(pkt_data_out), .pkt_valid_out(pkt_valid_out),
  .pkt_last_out(pkt_last_out), .pkt_len_out(pkt_len_out),
  .pkt_ready_in(pkt_ready_in), .net_connect_in(net_connect_in),
  .close_req_out(close_req_out), .listening_out(listening_out)
);

// [dv/serial_dev.sv]
// Model of the attached serial device and the network stack
`timescale 1ns/10ps
module serial_dev #(
  parameter int DIV = 86,
  parameter int LW = 4
) (
  // Clock
  input wire logic clk_sys_in,
  // Serial pins
  output logic rxd_out,
  output logic cts_out,
  input wire logic txd_in,
  input wire logic rts_in,
  // Packet stream
  input wire logic [7:0] pkt_data_in,
  input wire logic pkt_valid_in,
  input wire logic pkt_last_in,
  input wire logic [LW-1:0] pkt_len_in,
  output logic pkt_ready_out
);
  logic stall;
  logic [2:0] cyc;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int len_q[$];
  initial begin
    rxd_out = 1'b1;
    cts_out = 1'b1;
    pkt_ready_out = 1'b1;
    stall = 1'b0;
    cyc = 3'h0;
  end
  // Stalled network side takes one byte in eight cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 3'h1;
    pkt_ready_out <= !stall || cyc == 3'h7;
    if (pkt_valid_in && pkt_ready_out) begin
      rx_q.push_back(pkt_data_in);
      if (pkt_last_in) len_q.push_back(int'(pkt_len_in));
    end
  end
  // One 8N1 character, LSB first, called just after a clock edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (rts_in !== 1'b1) @(posedge clk_sys_in);
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (DIV) @(posedge clk_sys_in);
    end
  endtask
  // Samples mid-bit so a late start edge is tolerated
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd_in);
      repeat (DIV + DIV / 2) @(posedge clk_sys_in);
      for (int i = 0; i < 8; i++) begin
        b[i] = txd_in;
        repeat (DIV) @(posedge clk_sys_in);
      end
      tx_q.push_back(b);
    end
  end
endmodule // serial_dev

// [dv/serial_rx_packetizer_tb.sv]
// Self-checking testbench of the serial packetizer
`timescale 1ns/10ps
module serial_rx_packetizer_tb import serial_pkt_pkg::*;;
  localparam int DIV = 86;
  logic clk_sys_in, sys_rst_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, net_data, pkt_data;
  logic [31:0] pwdata, prdata, rd;
  logic rxd, cts, txd, rts, net_valid, net_ready, pkt_valid, pkt_last;
  logic pkt_ready, net_act, net_conn, close_req, listening, err, dtr;
  logic [3:0] pkt_len;
  logic [7:0] sent_q[$];
  int bad_count, n_compared;
  serial_rx_packetizer #(.FIFO_DEPTH(16), .BUF_BYTES(8), .MS_CYCLES(200))
  i_serial_rx_packetizer (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rxd_in(rxd), .cts_in(cts), .dsr_in(cts),
    .txd_out(txd), .rts_out(rts), .dtr_out(dtr), .net_data_in(net_data),
    .net_valid_in(net_valid), .net_ready_out(net_ready),
    .pkt_data_out(pkt_data), .pkt_valid_out(pkt_valid),
    .pkt_last_out(pkt_last), .pkt_len_out(pkt_len),
    .pkt_ready_in(pkt_ready), .net_activity_in(net_act),
    .net_connect_in(net_conn), .close_req_out(close_req),
    .listening_out(listening));
  serial_dev #(.DIV(DIV), .LW(4)) i_serial_dev (
    .clk_sys_in(clk_sys_in), .rxd_out(rxd), .cts_out(cts), .txd_in(txd),
    .rts_in(rts), .pkt_data_in(pkt_data), .pkt_valid_in(pkt_valid),
    .pkt_last_in(pkt_last), .pkt_len_in(pkt_len),
    .pkt_ready_out(pkt_ready));
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task test_done;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task send(input logic [7:0] b);
    sent_q.push_back(b);
    i_serial_dev.send(b);
  endtask
  task wait_pkt(input int n);
    int k;
    k = 0;
    while (i_serial_dev.len_q.size() == 0 && k < 3000) begin
      @(posedge clk_sys_in);
      k++;
    end
    chk(32'(i_serial_dev.len_q.size()), 32'h1, "packet count");
    if (i_serial_dev.len_q.size() != 0) begin
      chk(32'(i_serial_dev.len_q.pop_front()), 32'(n), "length");
      repeat (n) chk({24'h0, i_serial_dev.rx_q.pop_front()},
        {24'h0, sent_q.pop_front()}, "packet byte");
    end
  endtask
  task t_regs;
    logic [7:0] a[6];
    logic [31:0] e[6];
    a = '{A_CTRL, A_BAUD, A_DELIM, A_FLUSH, A_INACT, A_NIDLE};
    e = '{32'h283, 32'(DIV_RST), 32'h0, 32'h0, 32'h0, 32'h7};
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, e[i], "reset value");
    end
    chk({30'h0, rts, dtr}, 32'h3, "handshake idle");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read");
    apb(1'b1, A_BAUD, 32'h0000000a);
    apb(1'b0, A_BAUD, 32'h0);
    chk(rd, 32'(DIV_MIN), "rate clamp");
    apb(1'b1, A_BAUD, 32'(DIV));
    $display("register test done");
  endtask
  task t_delim;
    apb(1'b1, A_DELIM, 32'h0001000d);
    send(8'h41);
    send(8'h0d);
    wait_pkt(2);
    apb(1'b1, A_DELIM, 32'h00030a0d);
    i_serial_dev.stall = 1'b1;
    send(8'h0d);
    send(8'h41);
    send(8'h0d);
    send(8'h0a);
    wait_pkt(4);
    i_serial_dev.stall = 1'b0;
    $display("delimiter test done");
  endtask
  task t_idle;
    apb(1'b1, A_DELIM, 32'h0002aa55);
    apb(1'b1, A_FLUSH, 32'h0000000a);
    send(8'h55);
    send(8'haa);
    chk(32'(i_serial_dev.len_q.size()), 32'h0, "early flush");
    wait_pkt(2);
    apb(1'b1, A_FLUSH, 32'h0);
    $display("idle flush test done");
  endtask
  task t_full;
    i_serial_dev.stall = 1'b1;
    for (int i = 0; i < 8; i++) send(8'(8'h61 + i));
    wait_pkt(8);
    i_serial_dev.stall = 1'b0;
    $display("full buffer test done");
  endtask
  task t_tx;
    logic [7:0] b[3];
    int k;
    b = '{8'h3c, 8'hc3, 8'h5a};
    k = 0;
    i_serial_dev.cts_out <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    foreach (b[i]) begin
      net_data <= b[i];
      net_valid <= 1'b1;
      do @(posedge clk_sys_in); while (net_ready !== 1'b1);
    end
    net_valid <= 1'b0;
    repeat (100) @(posedge clk_sys_in);
    chk({31'h0, txd}, 32'h1, "cts hold");
    i_serial_dev.cts_out <= 1'b1;
    while (i_serial_dev.tx_q.size() < 3 && k < 4000) begin
      @(posedge clk_sys_in);
      k++;
    end
    foreach (b[i]) chk({24'h0, i_serial_dev.tx_q.pop_front()},
      {24'h0, b[i]}, "serial out");
    $display("transmit test done");
  endtask
  task t_close;
    int k;
    k = 0;
    net_conn <= 1'b1;
    @(posedge clk_sys_in);
    net_conn <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, listening}, 32'h0, "connected");
    apb(1'b1, A_INACT, 32'h00000014);
    send(8'h77);
    while (close_req !== 1'b1 && k < 5000) begin
      @(posedge clk_sys_in);
      k++;
    end
    chk(32'(k >= 3700 && k <= 4100), 32'h1, "close time");
    @(posedge clk_sys_in);
    chk({31'h0, listening}, 32'h1, "listening again");
    $display("inactivity test done");
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end
  initial begin
    sys_rst_in = 1'b1;
    {psel, penable, pwrite, net_valid, net_act, net_conn} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    net_data = 8'h0;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_regs;
    t_delim;
    t_idle;
    t_full;
    t_tx;
    t_close;
    test_done;
  end
endmodule // serial_rx_packetizer_tb
